// File: design/unbal_defines.svh
// Register offsets, field positions, reset values and timing counts of the unbalance block
`ifndef UNBAL_DEFINES_SVH
`define UNBAL_DEFINES_SVH

// ==========================================
// Register offsets
`define UB_REG_CTRL 8'h00
`define UB_REG_CLOSE_PU 8'h04
`define UB_REG_PEND_PU 8'h08
`define UB_REG_FAIL_PU 8'h0c
`define UB_REG_LOAD_THR 8'h10
`define UB_REG_STATUS 8'h14
`define UB_REG_EQ_BASE 8'h40
`define UB_EQ_COUNT 11

// ==========================================
// Control fields
`define UB_CTRL_DIV_LSB 0
`define UB_CTRL_MODE_LSB 4
`define UB_CTRL_RST 32'h00000000

// ==========================================
// Timing in quarter cycles (pickup maximum also in cycles), load threshold reset and divisor base shift
`define UB_QTR_PER_CYCLE 4
`define UB_PU_MAX_CYCLES 16383
`define UB_PU_MAX 16'hfffc
`define UB_PU_RST 16'h0000
`define UB_LOAD_THR_RST 16'h0001
`define UB_DIV_BASE_SHIFT 5'h03

// ==========================================
// Equation word: term mask, OR/AND select, output invert
`define UB_EQ_OP_BIT 16
`define UB_EQ_INV_BIT 17
`define UB_EQ_CLOSE_IN 32'h00010003
`define UB_EQ_LATCH_SET 32'h00000144
`define UB_EQ_LATCH_RST 32'h00020044
`define UB_EQ_PEND_A 32'h00000088
`define UB_EQ_PEND_B 32'h00000090
`define UB_EQ_PEND_C 32'h000000a0
`define UB_EQ_FAIL_A 32'h00000088
`define UB_EQ_FAIL_B 32'h00000090
`define UB_EQ_FAIL_C 32'h000000a0
`define UB_EQ_PEND_OUT 32'h00010e00
`define UB_EQ_FAIL_OUT 32'h00017000

`endif

// File: design/unbal_pkg.sv
// Types shared by the current unbalance failure logic
package unbal_pkg;

  typedef enum logic [1:0] {
    LOGIC_OFF = 2'h0,
    LOGIC_ON = 2'h1,
    LOGIC_CUSTOM = 2'h2
  } logic_sel_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } phase_mag_t;

  // Operand set that every equation may draw from
  typedef struct packed {
    logic const_one;
    logic [2:0] fail_out;
    logic [2:0] pend_out;
    logic close_out;
    logic latch_q;
    logic any_unbal;
    logic [2:0] unbal;
    logic load;
    logic manual_close;
    logic auto_close;
  } eq_terms_t;

endpackage

// File: design/pickup_timer.sv
// Pickup timer counting quarter cycles while its input stays asserted
`timescale 1ns/1ps
`default_nettype none

module pickup_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [15:0] pickup_i,
  output logic done_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic done_r;
  wire logic reached = (cnt_r >= pickup_i);

  // Counter saturates at the pickup so a lowered setting cannot wrap it
  assign cnt_nxt = !run_i ? 16'h0000 : (reached ? cnt_r : cnt_r + 16'h0001);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end else if (tick_i) begin
      cnt_r <= cnt_nxt;
      done_r <= run_i && (cnt_nxt >= pickup_i);
    end
  end

  assign done_o = done_r;

endmodule

`default_nettype wire

// File: design/unbal_failure_logic.sv
// Current unbalance pole-discordance and open-conductor failure logic with register port
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "unbal_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Unbalance divisor selectable among 8, 16, 32 and 64.
// - Phase flagged when its magnitude is below the three-phase sum over divisor.
// - Logic select offers off, default equations, or custom equations.
// - Custom mode lets every timer input and output be a user expression.
// - Close, pending and failure pickups span 0 to 16383 cycles, quarter steps.
// - Close timer input defaults to automatic OR manual close.
// - Latch sets on close timer output, load and any unbalance together.
// - Latch resets when load is lost or no phase is unbalanced.
// - Failure timers run on latch AND phase flag; failure output ORs them.
// - Pending-failure output is the OR of three pending timer outputs.
// - Default alarm and trip arise only after close operations.
// - Load detect asserts when a phase current exceeds its 0.01 A threshold.
module unbal_failure_logic (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic qtr_tick_i,
  input wire unbal_pkg::phase_mag_t phase_mag_i,
  input wire logic close_request_i,
  input wire logic manual_close_request_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  output logic load_detect_o,
  output logic [2:0] phase_unbalance_o,
  output logic unbalance_pending_failure_o,
  output logic unbalance_breaker_failure_o
);

  // ==========================================
  // Close inputs from pins
  logic [1:0] close_meta_r;
  logic [1:0] close_sync_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      close_meta_r <= 2'h0;
      close_sync_r <= 2'h0;
    end else begin
      close_meta_r <= {manual_close_request_i, close_request_i};
      close_sync_r <= close_meta_r;
    end
  end

  // ==========================================
  // Settings registers
  logic [1:0] divisor_code_r;
  unbal_pkg::logic_sel_t mode_r;
  logic [15:0] close_pu_r;
  logic [15:0] pend_pu_r;
  logic [15:0] fail_pu_r;
  logic [15:0] load_thr_r;
  logic [31:0] eq_r [`UB_EQ_COUNT];
  logic [31:0] eq_default [`UB_EQ_COUNT];

  assign eq_default[0] = `UB_EQ_CLOSE_IN;
  assign eq_default[1] = `UB_EQ_LATCH_SET;
  assign eq_default[2] = `UB_EQ_LATCH_RST;
  assign eq_default[3] = `UB_EQ_PEND_A;
  assign eq_default[4] = `UB_EQ_PEND_B;
  assign eq_default[5] = `UB_EQ_PEND_C;
  assign eq_default[6] = `UB_EQ_FAIL_A;
  assign eq_default[7] = `UB_EQ_FAIL_B;
  assign eq_default[8] = `UB_EQ_FAIL_C;
  assign eq_default[9] = `UB_EQ_PEND_OUT;
  assign eq_default[10] = `UB_EQ_FAIL_OUT;

  // ==========================================
  // Address decode
  wire logic sel_ctrl = (reg_addr_i == `UB_REG_CTRL);
  wire logic sel_close = (reg_addr_i == `UB_REG_CLOSE_PU);
  wire logic sel_pend = (reg_addr_i == `UB_REG_PEND_PU);
  wire logic sel_fail = (reg_addr_i == `UB_REG_FAIL_PU);
  wire logic sel_thr = (reg_addr_i == `UB_REG_LOAD_THR);
  wire logic sel_status = (reg_addr_i == `UB_REG_STATUS);
  wire logic [7:0] eq_offset = reg_addr_i - `UB_REG_EQ_BASE;
  wire logic [5:0] eq_index = eq_offset[7:2];
  wire logic sel_eq = (reg_addr_i >= `UB_REG_EQ_BASE)
    && (eq_offset[1:0] == 2'h0)
    && (eq_index < 6'(`UB_EQ_COUNT));

  // Pickups beyond 16383 cycles clamp rather than alias
  wire logic [15:0] wdata_pu = (reg_wdata_i[31:16] != 16'h0000)
    || (reg_wdata_i[15:0] > `UB_PU_MAX) ? `UB_PU_MAX : reg_wdata_i[15:0];

  // A literal cannot be part-selected, so the reset word is named first
  localparam logic [31:0] ctrl_rst = `UB_CTRL_RST;
  wire logic [1:0] wdata_mode = reg_wdata_i[`UB_CTRL_MODE_LSB +: 2];
  // The unused fourth code is refused so the mode stays a legal choice
  wire logic mode_legal = (wdata_mode != 2'h3);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      divisor_code_r <= ctrl_rst[`UB_CTRL_DIV_LSB +: 2];
      mode_r <= unbal_pkg::logic_sel_t'(ctrl_rst[`UB_CTRL_MODE_LSB +: 2]);
      close_pu_r <= `UB_PU_RST;
      pend_pu_r <= `UB_PU_RST;
      fail_pu_r <= `UB_PU_RST;
      load_thr_r <= `UB_LOAD_THR_RST;
    end else if (reg_write_i) begin
      if (sel_ctrl) begin
        divisor_code_r <= reg_wdata_i[`UB_CTRL_DIV_LSB +: 2];
        if (mode_legal) begin
          mode_r <= unbal_pkg::logic_sel_t'(wdata_mode);
        end
      end else if (sel_close) begin
        close_pu_r <= wdata_pu;
      end else if (sel_pend) begin
        pend_pu_r <= wdata_pu;
      end else if (sel_fail) begin
        fail_pu_r <= wdata_pu;
      end else if (sel_thr) begin
        load_thr_r <= reg_wdata_i[15:0];
      end
    end
  end

  // Equation words start as the defaults so custom mode begins from them
  genvar gi;
  generate
    for (gi = 0; gi < `UB_EQ_COUNT; gi++) begin : g_eq_reg
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          eq_r[gi] <= eq_default[gi];
        end else if (reg_write_i && sel_eq && (eq_index == 6'(gi))) begin
          eq_r[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ==========================================
  // Unbalance comparison and load detector
  logic [2:0] unbal_r;
  logic load_r;
  wire logic [15:0] mag [3];
  wire logic [17:0] mag_sum = {2'h0, phase_mag_i.a}
    + {2'h0, phase_mag_i.b}
    + {2'h0, phase_mag_i.c};
  wire logic [4:0] div_shift = `UB_DIV_BASE_SHIFT + {3'h0, divisor_code_r};
  wire logic [2:0] unbal_now;
  wire logic [2:0] over_thr;

  assign mag[0] = phase_mag_i.a;
  assign mag[1] = phase_mag_i.b;
  assign mag[2] = phase_mag_i.c;

  // Scaling the phase up instead of dividing the sum keeps the exact ratio
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      wire logic [21:0] scaled = {6'h00, mag[gi]} << div_shift;
      assign unbal_now[gi] = (scaled < {4'h0, mag_sum});
      assign over_thr[gi] = (mag[gi] > load_thr_r);
    end
  endgenerate

  wire logic enabled = (mode_r != unbal_pkg::LOGIC_OFF);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      unbal_r <= 3'h0;
      load_r <= 1'b0;
    end else if (qtr_tick_i) begin
      unbal_r <= unbal_now;
      load_r <= |over_thr;
    end
  end

  // ==========================================
  // Equation evaluation
  logic latch_r;
  logic pend_out_r;
  logic fail_out_r;
  logic close_done;
  logic [2:0] pend_done;
  logic [2:0] fail_done;
  unbal_pkg::eq_terms_t terms;
  wire logic [15:0] term_vec = terms;
  wire logic [`UB_EQ_COUNT-1:0] eq_val;

  assign terms.auto_close = close_sync_r[0];
  assign terms.manual_close = close_sync_r[1];
  assign terms.load = load_r;
  assign terms.unbal = unbal_r;
  assign terms.any_unbal = |unbal_r;
  assign terms.latch_q = latch_r;
  assign terms.close_out = close_done;
  assign terms.pend_out = pend_done;
  assign terms.fail_out = fail_done;
  assign terms.const_one = 1'b1;

  // Each word selects terms, joins them by AND or OR, then may invert
  generate
    for (gi = 0; gi < `UB_EQ_COUNT; gi++) begin : g_eq
      wire logic [31:0] word = (mode_r == unbal_pkg::LOGIC_CUSTOM)
        ? eq_r[gi] : eq_default[gi];
      wire logic [15:0] mask = word[15:0];
      wire logic any_sel = |(term_vec & mask);
      wire logic all_sel = (|mask) && (&(term_vec | ~mask));
      wire logic raw = word[`UB_EQ_OP_BIT] ? any_sel : all_sel;
      assign eq_val[gi] = enabled && (raw ^ word[`UB_EQ_INV_BIT]);
    end
  endgenerate

  // Default close input is automatic OR manual close
  wire logic close_timer_input = eq_val[0];
  wire logic unbalance_latch_set = eq_val[1];
  wire logic unbalance_latch_reset = eq_val[2];
  wire logic [2:0] pend_in = eq_val[5:3];
  wire logic [2:0] fail_in = eq_val[8:6];

  // ==========================================
  // Latch and outputs
  // Reset dominates so a set and reset together never leave the latch armed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      latch_r <= 1'b0;
      pend_out_r <= 1'b0;
      fail_out_r <= 1'b0;
    end else if (qtr_tick_i) begin
      if (unbalance_latch_reset || !enabled) begin
        latch_r <= 1'b0;
      end else if (unbalance_latch_set) begin
        latch_r <= 1'b1;
      end
      pend_out_r <= eq_val[9];
      fail_out_r <= eq_val[10];
    end
  end

  // ==========================================
  // Pickup timers: close, pending a..c, failure a..c
  wire logic [6:0] tmr_run = {fail_in, pend_in, close_timer_input};
  wire logic [15:0] tmr_pu [7];
  wire logic [6:0] tmr_done;

  assign tmr_pu[0] = close_pu_r;
  assign tmr_pu[1] = pend_pu_r;
  assign tmr_pu[2] = pend_pu_r;
  assign tmr_pu[3] = pend_pu_r;
  assign tmr_pu[4] = fail_pu_r;
  assign tmr_pu[5] = fail_pu_r;
  assign tmr_pu[6] = fail_pu_r;

  generate
    for (gi = 0; gi < 7; gi++) begin : g_tmr
      pickup_timer u_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(qtr_tick_i),
        .run_i(tmr_run[gi]),
        .pickup_i(tmr_pu[gi]),
        .done_o(tmr_done[gi])
      );
    end
  endgenerate

  assign close_done = tmr_done[0];
  assign pend_done = tmr_done[3:1];
  assign fail_done = tmr_done[6:4];

  // ==========================================
  // Register read port
  wire logic [31:0] ctrl_view = {26'h0, mode_r, 2'h0, divisor_code_r};
  wire logic [31:0] status_view = {
    18'h0,
    fail_out_r,
    pend_out_r,
    fail_done,
    pend_done,
    close_done,
    latch_r,
    load_r,
    unbal_r
  };
  wire logic [31:0] eq_view = sel_eq ? eq_r[eq_index[3:0]] : 32'h0;
  wire logic [31:0] rd_mux = sel_ctrl ? ctrl_view
    : sel_close ? {16'h0, close_pu_r}
    : sel_pend ? {16'h0, pend_pu_r}
    : sel_fail ? {16'h0, fail_pu_r}
    : sel_thr ? {16'h0, load_thr_r}
    : sel_status ? status_view
    : eq_view;

  logic [31:0] rdata_r;

  // Unmapped addresses read zero; data stands for the one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0;
    end else if (reg_read_i) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign load_detect_o = load_r;
  assign phase_unbalance_o = unbal_r;
  assign unbalance_pending_failure_o = pend_out_r;
  assign unbalance_breaker_failure_o = fail_out_r;

endmodule

`default_nettype wire

// File: bench/unbal_asserts.sv
// Port checker for the current unbalance failure logic
`timescale 1ns/1ps
`default_nettype none
module unbal_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic qtr_tick_i,
  input wire unbal_pkg::phase_mag_t phase_mag_i,
  input wire logic close_request_i,
  input wire logic manual_close_request_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic load_detect_o,
  input wire logic [2:0] phase_unbalance_o,
  input wire logic unbalance_pending_failure_o,
  input wire logic unbalance_breaker_failure_o
);
  // ==========================================
  // Shadow settings
  logic [1:0] div_r;
  logic [1:0] mode_r;
  logic [15:0] thr_r;
  logic seen_r;
  logic [3:0] quiet_r;
  wire [21:0] sum = phase_mag_i.a + phase_mag_i.b + phase_mag_i.c;
  // Divisor passed in so the flag model follows divisor writes at once
  function automatic logic low(input logic [15:0] m, input logic [1:0] d, input logic [21:0] s);
    return (({6'h00, m} << 3) << d) < s;
  endfunction
  wire [2:0] exp_flag = {low(phase_mag_i.c, div_r, sum), low(phase_mag_i.b, div_r, sum),
    low(phase_mag_i.a, div_r, sum)};
  wire ld = phase_mag_i.a > thr_r || phase_mag_i.b > thr_r || phase_mag_i.c > thr_r;
  // Off mode, or on mode with every phase balanced, must clear both outputs within four ticks
  wire quiet = mode_r == 2'h0 || (mode_r == 2'h1 && phase_unbalance_o == 3'h0);
  wire outs = unbalance_pending_failure_o || unbalance_breaker_failure_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      mode_r <= 2'h0;
      thr_r <= 16'h0001;
      seen_r <= 1'b0;
      quiet_r <= 4'h0;
    end else begin
      if (reg_write_i && reg_addr_i == 8'h00) begin
        div_r <= reg_wdata_i[1:0];
        if (reg_wdata_i[5:4] != 2'h3) begin
          mode_r <= reg_wdata_i[5:4];
        end
      end
      if (reg_write_i && reg_addr_i == 8'h10) begin
        thr_r <= reg_wdata_i[15:0];
      end
      if (close_request_i || manual_close_request_i) begin
        seen_r <= 1'b1;
      end
      if (!quiet) begin
        quiet_r <= 4'h0;
      end else if (qtr_tick_i && quiet_r != 4'hf) begin
        quiet_r <= quiet_r + 4'h1;
      end
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !outs && !load_detect_o
    && phase_unbalance_o == 3'h0) else $error("outputs not cleared by reset");
  a_flag_hold: assert property (!$past(qtr_tick_i) && !$past(rst_i)
    |-> $stable(phase_unbalance_o) && $stable(load_detect_o)) else $error("flag moved off tick");
  a_out_hold: assert property (!$past(qtr_tick_i) && !$past(rst_i) && !$past(reg_write_i)
    |-> $stable(outs)) else $error("output moved off tick");
  a_flag_ratio: assert property (qtr_tick_i && !reg_write_i
    |=> phase_unbalance_o == $past(exp_flag)) else $error("unbalance flag wrong");
  a_load_level: assert property (qtr_tick_i && !reg_write_i
    |=> load_detect_o == $past(ld)) else $error("load detect wrong");
  a_fail_after_close: assert property (mode_r == 2'h1 && $rose(outs) |-> seen_r)
    else $error("alarm without a close");
  a_quiet_clear: assert property (quiet_r >= 4'h4 |-> !outs)
    else $error("outputs held while quiet");
  a_read_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind unbal_failure_logic unbal_asserts i_unbal_asserts (.sys_clk_i, .rst_i, .qtr_tick_i,
  .phase_mag_i, .close_request_i, .manual_close_request_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .load_detect_o, .phase_unbalance_o,
  .unbalance_pending_failure_o, .unbalance_breaker_failure_o);
`default_nettype wire

// File: bench/breaker_model.sv
// Breaker model: raises close signals on command, opens on a trip
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(parameter int HOLD = 400) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] close_cmd_i,
  input wire logic trip_i,
  output logic close_request_o,
  output logic manual_close_request_o
);
  logic [1:0] on_r;
  int cnt;
  assign close_request_o = on_r[0];
  assign manual_close_request_o = on_r[1];
  // A trip opens the breaker at once, so the close signal never outlives it
  always @(posedge sys_clk_i) begin
    if (rst_i || trip_i || cnt == 1) begin
      on_r <= 2'h0;
      cnt <= 0;
    end else if (close_cmd_i != 2'h0) begin
      on_r <= close_cmd_i;
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// File: bench/unbal_failure_logic_tb.sv
// Self-checking bench for the current unbalance failure logic
`timescale 1ns/1ps
`default_nettype none
module unbal_failure_logic_tb;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic qtr_tick_i = 0;
  logic reg_write_i = 0;
  logic reg_read_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  unbal_pkg::phase_mag_t phase_mag_i = '0;
  logic [1:0] cmd = 2'h0;
  logic close_request_i, manual_close_request_i, load_detect_o, pend, fail;
  logic [2:0] phase_unbalance_o;
  int err_total = 0;
  int checked = 0;
  int tq = 0;
  unbal_failure_logic i_unbal_failure_logic (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .qtr_tick_i(qtr_tick_i), .phase_mag_i(phase_mag_i), .close_request_i(close_request_i),
    .manual_close_request_i(manual_close_request_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .load_detect_o(load_detect_o),
    .phase_unbalance_o(phase_unbalance_o), .unbalance_pending_failure_o(pend),
    .unbalance_breaker_failure_o(fail));
  breaker_model i_breaker_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .close_cmd_i(cmd),
    .trip_i(fail), .close_request_o(close_request_i),
    .manual_close_request_o(manual_close_request_i));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // One quarter-cycle strobe every four clocks keeps the run short
  always @(posedge sys_clk_i) begin
    tq <= (tq + 1) % 4;
    qtr_tick_i <= tq == 3;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    #1 chk(n, reg_rdata_o, e);
  endtask
  task automatic ticks(input int n);
    repeat (4 * n) @(posedge sys_clk_i);
  endtask
  task automatic wait_out(input bit f, input int lim);
    for (int i = 0; i < lim && (f ? fail : pend) !== 1'b1; i++) @(posedge sys_clk_i);
  endtask
  task automatic close_cmd(input logic [1:0] kind);
    @(posedge sys_clk_i);
    cmd <= kind;
    @(posedge sys_clk_i);
    cmd <= 2'h0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rdc("ctrl", 8'h00, 32'h0);
    rdc("close pickup", 8'h04, 32'h0);
    rdc("threshold", 8'h10, 32'h1);
    rdc("close eq", 8'h40, 32'h00010003);
    rdc("unmapped", 8'h30, 32'h0);
    wr(8'h04, 32'hffffffff);
    rdc("pickup clamp", 8'h04, 32'hfffc);
    wr(8'h14, 32'hffffffff);
    rdc("status", 8'h14, 32'h0);
    wr(8'h04, 32'h18);
    rdc("close pickup 6 cycles", 8'h04, 32'h18);
    wr(8'h08, 32'h1c20);
    rdc("pending pickup 1800", 8'h08, 32'h1c20);
    wr(8'h00, 32'h33);
    rdc("mode 3", 8'h00, 32'h3);
  endtask
  task automatic t_flags;
    logic [15:0] c;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        c = 16'(32'h7d0 / ((8 << k) - 1) + j);
        wr(8'h00, 32'h10 | 32'(k));
        phase_mag_i <= {16'h03e8, 16'h03e8, c};
        ticks(3);
        chk("flags", 32'(phase_unbalance_o), 32'(32'(c) * (8 << k) < 32'h7d0 + c) << 2);
      end
    end
    phase_mag_i <= {3{16'h03e8}};
    wr(8'h10, 32'h3e8);
    ticks(3);
    chk("load at threshold", 32'(load_detect_o), 32'h0);
    wr(8'h10, 32'h3e7);
    ticks(3);
    chk("load above", 32'(load_detect_o), 32'h1);
  endtask
  task automatic t_close(input logic [1:0] kind);
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h8);
    wr(8'h0c, 32'h20);
    phase_mag_i <= {16'h03e8, 16'h03e8, 16'h0000};
    ticks(20);
    chk("before close", 32'({pend, fail}), 32'h0);
    close_cmd(kind);
    wait_out(0, 200);
    chk("pending", 32'({pend, fail}), 32'h2);
    wait_out(1, 400);
    chk("failure", 32'(fail), 32'h1);
    phase_mag_i <= {3{16'h03e8}};
    ticks(6);
    chk("balanced", 32'({pend, fail}), 32'h0);
  endtask
  task automatic t_off;
    wr(8'h00, 32'h0);
    phase_mag_i <= {16'h03e8, 16'h03e8, 16'h0000};
    close_cmd(2'h1);
    ticks(110);
    chk("off mode", 32'({pend, fail}), 32'h0);
  endtask
  task automatic t_custom;
    for (int i = 0; i < 3; i++) begin
      wr(8'h4c + 8'(4 * i), 32'h4 | (32'h8 << i));
    end
    wr(8'h00, 32'h20);
    wait_out(0, 200);
    chk("open conductor", 32'({pend, fail}), 32'h2);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_flags();
    t_close(2'h1);
    t_close(2'h2);
    t_off();
    t_custom();
    print_verdict();
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
